// *** inc/sfm_pkg.sv ***
// Constants, register map and types of the supply fault event monitor.
// Assumes a single 100 MHz clock and an SPI host as register master.
package sfm_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int STARTUP_DELAY_MS = 15;
	localparam int STAGGER_DELAY_MS = 2;
	localparam int STARTUP_CYC = CLK_HZ / 1000 * STARTUP_DELAY_MS;
	localparam int STAGGER_CYC = CLK_HZ / 1000 * STAGGER_DELAY_MS;
	localparam int CNT_W = 21;

	localparam int ADDR_W = 7;
	localparam int FRAME_BITS = 16;
	localparam logic [6:0] ADDR_BUCK_CTRL = 7'h0A;
	localparam logic [6:0] ADDR_CMP_CTRL = 7'h0B;
	localparam logic [6:0] ADDR_EVT_EN = 7'h0C;
	localparam logic [6:0] ADDR_EVT_STAT = 7'h0D;
	localparam logic [6:0] ADDR_EVT_CFG = 7'h0E;

	localparam logic [7:0] RST_BUCK_CTRL = 8'h03;
	localparam logic [7:0] RST_CMP_CTRL = 8'h00;
	localparam logic [7:0] RST_EVT_EN = 8'h0F;
	localparam logic [7:0] RST_EVT_CFG = 8'h00;

	localparam int REGULATOR_OUTPUT_ENABLE_BUCK1_BIT = 0;
	localparam int REGULATOR_OUTPUT_ENABLE_BUCK2_BIT = 1;
	localparam int CMP_HYST_X2_BIT = 7;
	localparam int CMP_OFS_MSB = 6;
	localparam int EVT_POL_BIT = 0;
	localparam int EVT_BUCK2_BIT = 0;
	localparam int EVT_BUCK1_BIT = 1;
	localparam int EVT_LDO_BIT = 2;
	localparam int EVT_CMP_BIT = 3;

	localparam int MV_W = 13;
	localparam int THR_DEFAULT_MV = 2794;
	localparam int THR_STEP_MV = 31;
	localparam int THR_MIN_MV = 2000;
	localparam int THR_MAX_MV = 4000;
	localparam int CMP_HYST_MV = 60;

	typedef enum logic [2:0] {
		SEQ_LOCKOUT = 3'b000,
		SEQ_WAIT_START = 3'b001,
		SEQ_LDO = 3'b010,
		SEQ_BUCK1 = 3'b011,
		SEQ_ACTIVE = 3'b100
	} sfm_seq_state_t;

	typedef struct packed {
		logic low_supply_lockout;
		logic high_supply_lockout;
		logic thermal_trip;
		logic lockout_cutoff;
	} sfm_supply_ind_t;

	typedef struct packed {
		logic ldo;
		logic buck1;
		logic buck2;
	} sfm_rails_t;
endpackage

// *** core/sfm_sync.sv ***
// Two-stage synchroniser for a group of slow asynchronous levels.
// Assumes each bit is a level that stays put for several clocks.
`timescale 1ns/10ps
module sfm_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// First stage feeds only the second
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta_q <= INIT;
			sync_q <= INIT;
		end
		else if (ce_i)
		begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule

// *** core/sfm_hyst.sv ***
// Set/clear flag with hysteresis taken from two thresholds.
// Assumes set and clear never both hold for a sane threshold pair.
`timescale 1ns/10ps
module sfm_hyst (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic en_i,
	input wire logic set_i,
	input wire logic clr_i,
	output logic flag_o
);
	logic flag_q;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			flag_q <= 1'b0;
		else if (ce_i)
		begin
			if (!en_i)
				flag_q <= 1'b0;
			else if (set_i)
				flag_q <= 1'b1;
			else if (clr_i)
				flag_q <= 1'b0;
		end
	end

	assign flag_o = flag_q;
endmodule

// *** core/sfm_monitor.sv ***
// Supply fault event monitor: lockout, power-up sequencing, events, SPI.
// Assumes digitised analog indications and an SPI host on slow pins.
//
// Behaviour
// - Undervoltage lockout turns both bucks off and resets all registers.
// - Leaving undervoltage lockout runs power-up sequence, then active.
// - Overvoltage lockout disables bucks and LDO, resets all registers.
// - Leaving overvoltage lockout runs power-up sequence, then active.
// - In undervoltage lockout LDO and comparator run until cut-off level.
// - Host can read event enable and event status over SPI.
// - Event status is live, never latched, never cleared by reads.
// - Detected event sets its status bit and asserts interrupt.
// - Four sources: buck 2, buck 1, LDO power-good, comparator.
// - Reads never release the interrupt; it follows live conditions.
// - Each event source enabled by one, disabled by zero.
// - Thermal trip holds reset, all off, then power-up on recovery.
// - After thermal recovery every register holds its default.
// - Comparator threshold programmable 2.0 V to 4.0 V in steps.
// - Polarity zero: interrupt low while input above threshold.
// - Polarity one: interrupt high while input above threshold.
// - Comparator falling hysteresis, doubled by a control bit.
// - Reset pin low returns all registers to defaults.
// - Wait 15 ms, LDO, 2 ms, buck 1, 2 ms, buck 2.
// - Host may switch each buck off by clearing its enable bit.
`timescale 1ns/10ps
module sfm_monitor #(
	parameter int STARTUP_CYCLES = sfm_pkg::STARTUP_CYC,
	parameter int STAGGER_CYCLES = sfm_pkg::STAGGER_CYC
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire sfm_pkg::sfm_supply_ind_t supply_ind_i,
	input wire logic reset_pin_n_i,
	input wire logic [2:0] pg_rise_i,
	input wire logic [2:0] pg_hold_i,
	input wire logic [sfm_pkg::MV_W-1:0] monitored_comparator_input_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_clk_i,
	input wire logic spi_di_i,
	output logic spi_do_o,
	output logic spi_do_oe_o,
	output sfm_pkg::sfm_rails_t rail_en_o,
	output logic cmp_active_o,
	output logic irq_o
);
	import sfm_pkg::*;

	localparam int SYNC_W = 14;
	localparam logic [SYNC_W-1:0] SYNC_INIT = 14'h2204;

	logic [SYNC_W-1:0] sync_s;
	logic [MV_W-1:0] monitored_comparator_input_raw;
	logic [MV_W-1:0] monitored_comparator_input_p_q;
	logic [MV_W-1:0] monitored_comparator_input_q;
	logic uv_s;
	logic ov_s;
	logic tsd_s;
	logic cutoff_s;
	logic rst_pin_s;
	logic [2:0] pg_rise_s;
	logic [2:0] pg_hold_s;
	logic cs_n_s;
	logic sclk_s;
	logic di_s;
	logic seq_fault;
	logic reg_clear;

	sfm_sync #(
		.W(SYNC_W),
		.INIT(SYNC_INIT)
	) u_sync_pins (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.d_i({supply_ind_i, reset_pin_n_i, pg_rise_i, pg_hold_i,
			spi_cs_n_i, spi_clk_i, spi_di_i}),
		.q_o(sync_s)
	);

	// Bits may skew through sync; the filter below takes settled words
	sfm_sync #(
		.W(MV_W),
		.INIT('0)
	) u_sync_monitored_comparator_input (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.d_i(monitored_comparator_input_i),
		.q_o(monitored_comparator_input_raw)
	);

	// Word taken only when two synced samples agree
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			monitored_comparator_input_p_q <= '0;
			monitored_comparator_input_q <= '0;
		end
		else if (ce_i)
		begin
			monitored_comparator_input_p_q <= monitored_comparator_input_raw;
			if (monitored_comparator_input_raw == monitored_comparator_input_p_q)
				monitored_comparator_input_q <= monitored_comparator_input_raw;
		end
	end

	assign {uv_s, ov_s, tsd_s, cutoff_s} = sync_s[13:10];
	assign rst_pin_s = sync_s[9];
	assign pg_rise_s = sync_s[8:6];
	assign pg_hold_s = sync_s[5:3];
	assign cs_n_s = sync_s[2];
	assign sclk_s = sync_s[1];
	assign di_s = sync_s[0];

	assign seq_fault = uv_s | ov_s | tsd_s;
	// register defaults on any fault or pin
	assign reg_clear = seq_fault | ~rst_pin_s;

	sfm_seq_state_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic ldo_hold_q;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_q <= SEQ_LOCKOUT;
			cnt_q <= '0;
		end
		else if (ce_i)
		begin
			if (seq_fault)
			begin
				state_q <= SEQ_LOCKOUT;
				cnt_q <= '0;
			end
			else
			begin
				case (state_q)
					SEQ_LOCKOUT:
					begin
						state_q <= SEQ_WAIT_START;
						cnt_q <= '0;
					end
					SEQ_WAIT_START:
					begin
						if (cnt_q == CNT_W'(STARTUP_CYCLES - 1))
						begin
							state_q <= SEQ_LDO;
							cnt_q <= '0;
						end
						else
							cnt_q <= cnt_q + 1'b1;
					end
					SEQ_LDO:
					begin
						if (cnt_q == CNT_W'(STAGGER_CYCLES - 1))
						begin
							state_q <= SEQ_BUCK1;
							cnt_q <= '0;
						end
						else
							cnt_q <= cnt_q + 1'b1;
					end
					SEQ_BUCK1:
					begin
						if (cnt_q == CNT_W'(STAGGER_CYCLES - 1))
						begin
							state_q <= SEQ_ACTIVE;
							cnt_q <= '0;
						end
						else
							cnt_q <= cnt_q + 1'b1;
					end
					SEQ_ACTIVE:
						cnt_q <= '0;
					default:
					begin
						state_q <= SEQ_LOCKOUT;
						cnt_q <= '0;
					end
				endcase
			end
		end
	end

	// LDO rides through undervoltage down to cut-off
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			ldo_hold_q <= 1'b0;
		else if (ce_i)
		begin
			if (ov_s | tsd_s | cutoff_s)
				ldo_hold_q <= 1'b0;
			else if (!uv_s && state_q != SEQ_LOCKOUT &&
				state_q != SEQ_WAIT_START)
				ldo_hold_q <= 1'b1;
		end
	end

	logic [7:0] buck_ctrl_q;
	logic [7:0] cmp_ctrl_q;
	logic [7:0] evt_en_q;
	logic [7:0] evt_cfg_q;
	logic wr_stb;
	logic [ADDR_W-1:0] wr_addr;
	logic [7:0] wr_data;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			buck_ctrl_q <= RST_BUCK_CTRL;
			cmp_ctrl_q <= RST_CMP_CTRL;
			evt_en_q <= RST_EVT_EN;
			evt_cfg_q <= RST_EVT_CFG;
		end
		else if (ce_i)
		begin
			if (reg_clear)
			begin
				buck_ctrl_q <= RST_BUCK_CTRL;
				cmp_ctrl_q <= RST_CMP_CTRL;
				evt_en_q <= RST_EVT_EN;
				evt_cfg_q <= RST_EVT_CFG;
			end
			else if (wr_stb)
			begin
				if (wr_addr == ADDR_BUCK_CTRL)
					buck_ctrl_q <= wr_data & 8'h03;
				else if (wr_addr == ADDR_CMP_CTRL)
					cmp_ctrl_q <= wr_data;
				else if (wr_addr == ADDR_EVT_EN)
					evt_en_q <= wr_data & 8'h0F;
				else if (wr_addr == ADDR_EVT_CFG)
					evt_cfg_q <= wr_data & 8'h01;
			end
		end
	end

	sfm_rails_t rails_q;

	// bucks off in lockout, LDO held through UV lockout to cut-off; per-buck enable
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rails_q <= '0;
		else if (ce_i)
		begin
			rails_q.ldo <= (!seq_fault && (state_q == SEQ_LDO ||
				state_q == SEQ_BUCK1 || state_q == SEQ_ACTIVE)) ||
				(uv_s && ldo_hold_q && !ov_s && !tsd_s && !cutoff_s);
			rails_q.buck1 <= !seq_fault && !reg_clear &&
				(state_q == SEQ_BUCK1 || state_q == SEQ_ACTIVE) &&
				buck_ctrl_q[REGULATOR_OUTPUT_ENABLE_BUCK1_BIT];
			rails_q.buck2 <= !seq_fault && !reg_clear &&
				state_q == SEQ_ACTIVE && buck_ctrl_q[REGULATOR_OUTPUT_ENABLE_BUCK2_BIT];
		end
	end
	assign rail_en_o = rails_q;

	logic cmp_on;
	logic [MV_W-1:0] thr_mv;
	logic [MV_W-1:0] hyst_mv;
	logic cmp_flag;
	logic [2:0] pg_flag;
	int thr_calc;

	// comparator alive until cut-off, off in OV and thermal
	assign cmp_on = !ov_s && !tsd_s && !cutoff_s;

	// threshold from signed step offset, clamped to range
	always_comb
	begin
		thr_calc = THR_DEFAULT_MV + THR_STEP_MV *
			int'(signed'(cmp_ctrl_q[CMP_OFS_MSB:0]));
		if (thr_calc < THR_MIN_MV)
			thr_calc = THR_MIN_MV;
		else if (thr_calc > THR_MAX_MV)
			thr_calc = THR_MAX_MV;
		thr_mv = MV_W'(thr_calc);
	end

	assign hyst_mv = cmp_ctrl_q[CMP_HYST_X2_BIT] ?
		MV_W'(2 * CMP_HYST_MV) : MV_W'(CMP_HYST_MV);

	sfm_hyst u_cmp (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.en_i(cmp_on),
		.set_i(monitored_comparator_input_q > thr_mv),
		.clr_i(monitored_comparator_input_q < thr_mv - hyst_mv),
		.flag_o(cmp_flag)
	);

	// power-good flags: set above 90 %, drop below 85 %
	for (genvar g = 0; g < 3; g++)
	begin : g_pg
		sfm_hyst u_pg (
			.clk_i(clk_i),
			.arst_n_i(arst_n_i),
			.ce_i(ce_i),
			.en_i(rails_q[2-g]),
			.set_i(pg_rise_s[g]),
			.clr_i(!pg_hold_s[g]),
			.flag_o(pg_flag[g])
		);
	end

	logic [7:0] evt_stat;
	logic irq_q;

	assign evt_stat = {4'h0, cmp_flag, pg_flag[0], pg_flag[1], pg_flag[2]};

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			irq_q <= 1'b1;
		else if (ce_i)
		begin
			if (evt_cfg_q[EVT_POL_BIT])
				irq_q <= |(evt_stat & evt_en_q);
			else
				irq_q <= ~|(evt_stat & evt_en_q);
		end
	end
	assign irq_o = irq_q;
	assign cmp_active_o = cmp_on;

	logic sclk_d_q;
	logic [3:0] bit_cnt_q;
	logic [FRAME_BITS-2:0] shift_q;
	logic rd_q;
	logic [ADDR_W-1:0] addr_q;
	logic [7:0] tx_q;
	logic do_q;
	logic sclk_rise;
	logic sclk_fall;
	logic [7:0] hdr;
	logic [7:0] rd_data;

	assign sclk_rise = sclk_s & ~sclk_d_q;
	assign sclk_fall = ~sclk_s & sclk_d_q;
	assign hdr = {shift_q[6:0], di_s};

	// read mux; status reads have no side effect
	always_comb
	begin
		if (hdr[ADDR_W-1:0] == ADDR_BUCK_CTRL)
			rd_data = buck_ctrl_q;
		else if (hdr[ADDR_W-1:0] == ADDR_CMP_CTRL)
			rd_data = cmp_ctrl_q;
		else if (hdr[ADDR_W-1:0] == ADDR_EVT_EN)
			rd_data = evt_en_q;
		else if (hdr[ADDR_W-1:0] == ADDR_EVT_STAT)
			rd_data = evt_stat;
		else if (hdr[ADDR_W-1:0] == ADDR_EVT_CFG)
			rd_data = evt_cfg_q;
		else
			rd_data = 8'h00;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			sclk_d_q <= 1'b0;
		else if (ce_i)
			sclk_d_q <= sclk_s;
	end

	// Frame: R/W, 7-bit address, 8 data bits, MSB first
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			bit_cnt_q <= '0;
			shift_q <= '0;
			rd_q <= 1'b0;
			addr_q <= '0;
			tx_q <= '0;
			do_q <= 1'b0;
		end
		else if (ce_i)
		begin
			if (cs_n_s || reg_clear)
			begin
				bit_cnt_q <= '0;
				do_q <= 1'b0;
			end
			else
			begin
				if (sclk_rise)
				begin
					shift_q <= {shift_q[FRAME_BITS-3:0], di_s};
					bit_cnt_q <= bit_cnt_q + 1'b1;
					if (bit_cnt_q == 4'h7)
					begin
						rd_q <= hdr[7];
						addr_q <= hdr[ADDR_W-1:0];
						tx_q <= hdr[7] ? rd_data : 8'h00;
					end
				end
				else if (sclk_fall)
				begin
					do_q <= tx_q[7];
					tx_q <= {tx_q[6:0], 1'b0};
				end
			end
		end
	end

	// Write lands on the last rising edge of a write frame
	assign wr_stb = ce_i && !cs_n_s && sclk_rise &&
		bit_cnt_q == 4'hF && !rd_q;
	assign wr_addr = addr_q;
	assign wr_data = {shift_q[6:0], di_s};

	assign spi_do_o = do_q;
	assign spi_do_oe_o = ~cs_n_s;
endmodule

// *** tb/sfm_asserts.sv ***
// Port checker for sfm_monitor, bound to the design below.
// Assumes the shortened sequencer counts handed on by the bind.
`timescale 1ns/10ps
module sfm_asserts #(
	parameter int STARTUP_CYCLES = sfm_pkg::STARTUP_CYC,
	parameter int STAGGER_CYCLES = sfm_pkg::STAGGER_CYC
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire sfm_pkg::sfm_supply_ind_t supply_ind_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_do_o,
	input wire logic spi_do_oe_o,
	input wire sfm_pkg::sfm_rails_t rail_en_o,
	input wire logic cmp_active_o
);
	import sfm_pkg::*;
	int clean_q;
	int ldo_cnt_q;
	logic uv, ov, th, cut, flt;
	assign {uv, ov, th, cut} = supply_ind_i;
	assign flt = uv | ov | th;
	// Saturating count of fault-free cycles
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			clean_q <= 0;
		else if (flt)
			clean_q <= 0;
		else if (ce_i && clean_q < STARTUP_CYCLES)
			clean_q <= clean_q + 1;
	end
	// Saturating count of cycles with the LDO up
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			ldo_cnt_q <= 0;
		else if (!rail_en_o.ldo)
			ldo_cnt_q <= 0;
		else if (ce_i && ldo_cnt_q < STAGGER_CYCLES)
			ldo_cnt_q <= ldo_cnt_q + 1;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	a_uv_bucks_off: assert property (uv [*6]
		|-> !rail_en_o.buck1 && !rail_en_o.buck2) else $error("buck on");
	a_ov_rails_off: assert property (ov [*6]
		|-> rail_en_o == 3'h0) else $error("rail on in overvoltage");
	a_trip_all_off: assert property (th [*6]
		|-> rail_en_o == 3'h0 && !cmp_active_o) else $error("on in trip");
	a_cut_cmp_off: assert property (cut [*4] |-> !cmp_active_o)
		else $error("comparator on past cut-off");
	a_uv_cmp_on: assert property ((uv && !ov && !th && !cut) [*4]
		|-> cmp_active_o) else $error("comparator off in lockout");
	a_sync_delay: assert property ($rose(flt) && rail_en_o.ldo
		|=> rail_en_o.ldo) else $error("fault used unsynchronised");
	a_ldo_first: assert property ($rose(rail_en_o.buck1)
		|| $rose(rail_en_o.buck2) |-> rail_en_o.ldo) else $error("order");
	a_buck_stagger: assert property ($rose(rail_en_o.ldo)
		|-> !rail_en_o.buck1 [*8]) else $error("buck1 too early");
	a_buck1_gap: assert property ($rose(rail_en_o.buck1)
		|-> ldo_cnt_q >= STAGGER_CYCLES) else $error("buck1 gap short");
	a_startup_wait: assert property ($rose(rail_en_o.ldo)
		|-> clean_q >= STARTUP_CYCLES) else $error("startup too short");
	a_cs_idle_quiet: assert property (spi_cs_n_i [*4]
		|-> !spi_do_oe_o && !spi_do_o) else $error("data out while idle");
	c_ldo_up: cover property ($rose(rail_en_o.ldo));
	c_all_on: cover property (rail_en_o == 3'h7);
	c_read_one: cover property (spi_do_oe_o && spi_do_o);
endmodule

bind sfm_monitor sfm_asserts #(
	.STARTUP_CYCLES(STARTUP_CYCLES),
	.STAGGER_CYCLES(STAGGER_CYCLES)
) u_chk (
	.clk_i(clk_i),
	.arst_n_i(arst_n_i),
	.ce_i(ce_i),
	.supply_ind_i(supply_ind_i),
	.spi_cs_n_i(spi_cs_n_i),
	.spi_do_o(spi_do_o),
	.spi_do_oe_o(spi_do_oe_o),
	.rail_en_o(rail_en_o),
	.cmp_active_o(cmp_active_o)
);

// *** tb/sfm_host.sv ***
// SPI mode 0 host model, 16-bit frames, MSB first.
// Assumes the design clock; each SCLK phase lasts five clocks.
`timescale 1ns/10ps
module sfm_host (
	input wire logic clk_i,
	input wire logic do_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic di_o
);
	localparam int HALF = 5;
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		di_o = 1'b0;
	end
	task automatic xfer(input logic rw, input logic [6:0] a,
		input logic [7:0] wd, output logic [7:0] rd);
		logic [15:0] f;
		f = {rw, a, wd};
		rd = 8'h00;
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		repeat (HALF) @(posedge clk_i);
		for (int i = 15; i >= 0; i--)
		begin
			di_o <= f[i];
			sclk_o <= 1'b0;
			repeat (HALF) @(posedge clk_i);
			if (i < 8)
				rd[i] = do_i;
			sclk_o <= 1'b1;
			repeat (HALF) @(posedge clk_i);
		end
		sclk_o <= 1'b0;
		repeat (HALF) @(posedge clk_i);
		cs_n_o <= 1'b1;
		// Deselected line must not keep the last bit
		di_o <= ~f[0];
		repeat (HALF) @(posedge clk_i);
	endtask
endmodule

// *** tb/supply_fault_event_monitor_bench.sv ***
// Self-checking bench for sfm_monitor with a behavioural event model.
// Assumes sfm_host as SPI master and sfm_asserts bound to the design.
`timescale 1ns/10ps
module supply_fault_event_monitor_bench;
	import sfm_pkg::*;
	localparam int ST = 20;
	localparam int SG = 10;
	localparam int UP = ST + 3 * SG + 20;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic rst_n = 1'b1;
	logic cs_n, sclk, di, sdo, cmp_act, irq, cmp_m, e_irq;
	logic [2:0] rise = 3'h0, hold = 3'h0, pg_m;
	logic [12:0] input_supply = 13'h0AF0;
	logic [7:0] rd, bk, cc, en, cfg, stat;
	logic [31:0] r;
	logic [6:0] ad [5] = '{ADDR_BUCK_CTRL, ADDR_CMP_CTRL, ADDR_EVT_EN,
		ADDR_EVT_CFG, 7'h20};
	logic [7:0] dv [5] = '{8'h03, 8'h00, 8'h0F, 8'h00, 8'h00};
	logic [7:0] fr [4] = '{8'h04, 8'h00, 8'h00, 8'h04};
	logic fc [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
	sfm_supply_ind_t ind = '0;
	sfm_rails_t rails;
	int err_total = 0;
	int n_tests = 0;
	int seed = 32'hED17;
	int thr;
	always #5 clk_i = ~clk_i;
	sfm_monitor #(.STARTUP_CYCLES(ST), .STAGGER_CYCLES(SG)) DUT (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
		.supply_ind_i(ind), .reset_pin_n_i(rst_n), .pg_rise_i(rise),
		.pg_hold_i(hold), .monitored_comparator_input_i(input_supply),
		.spi_cs_n_i(cs_n), .spi_clk_i(sclk), .spi_di_i(di),
		.spi_do_o(sdo), .spi_do_oe_o(), .rail_en_o(rails),
		.cmp_active_o(cmp_act), .irq_o(irq));
	sfm_host host (.clk_i(clk_i), .do_i(sdo), .cs_n_o(cs_n),
		.sclk_o(sclk), .di_o(di));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("errors=%0d checks=%0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer(1'b0, a, d, rd);
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		host.xfer(1'b1, a, 8'h00, rd);
		chk(rd, e);
	endtask
	// Live flags with hysteresis, rails gated by buck enables
	function automatic void step();
		int off;
		off = $signed(cc[6:0]);
		thr = THR_DEFAULT_MV + THR_STEP_MV * off;
		if (thr < THR_MIN_MV)
			thr = THR_MIN_MV;
		if (thr > THR_MAX_MV)
			thr = THR_MAX_MV;
		if (input_supply > thr)
			cmp_m = 1'b1;
		else if (input_supply < thr - CMP_HYST_MV * (cc[7] + 1))
			cmp_m = 1'b0;
		for (int i = 0; i < 3; i++)
			if (!hold[i] || (i > 0 && !bk[i - 1]))
				pg_m[i] = 1'b0;
			else if (rise[i])
				pg_m[i] = 1'b1;
		stat = {4'h0, cmp_m, pg_m[0], pg_m[1], pg_m[2]};
		e_irq = cfg[0] ? |(stat & en) : ~|(stat & en);
	endfunction
	initial
	begin
		bk = 8'h03;
		cc = 8'h00;
		en = 8'h0F;
		cfg = 8'h00;
		pg_m = 3'h0;
		cmp_m = 1'b0;
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (UP) @(posedge clk_i);
		chk({5'h0, rails}, 8'h07);
		wr(ADDR_EVT_STAT, 8'hFF);
		wr(7'h20, 8'hFF);
		for (int i = 0; i < 5; i++)
			rdchk(ad[i], dv[i]);
		step();
		for (int n = 0; n < 24; n++)
		begin
			r = $random(seed);
			bk = {6'h0, r[1:0]};
			cc = r[15:8];
			en = {4'h0, r[19:16]};
			cfg = {7'h0, r[20]};
			wr(ADDR_BUCK_CTRL, bk);
			step();
			wr(ADDR_CMP_CTRL, cc);
			step();
			wr(ADDR_EVT_EN, en);
			wr(ADDR_EVT_CFG, cfg);
			r = $random(seed);
			@(posedge clk_i);
			rise <= r[2:0];
			hold <= r[2:0] | r[5:3];
			input_supply <= r[6] ? 13'(thr - r[13:7]) : 13'(1850 + r[27:16] % 2300);
			repeat (8) @(posedge clk_i);
			step();
			chk({7'h0, irq}, {7'h0, e_irq});
			chk({5'h0, rails}, {6'h01, bk[0], bk[1]});
			rdchk(ADDR_EVT_STAT, stat);
			rdchk(ADDR_EVT_STAT, stat);
			chk({7'h0, irq}, {7'h0, e_irq});
			rdchk(ADDR_EVT_EN, en);
		end
		for (int k = 0; k < 4; k++)
		begin
			wr(ADDR_EVT_EN, 8'h05);
			ind <= (k < 3) ? 4'h8 >> k : 4'h0;
			rst_n <= (k != 3);
			repeat (10) @(posedge clk_i);
			chk({5'h0, rails}, fr[k]);
			chk({7'h0, cmp_act}, {7'h0, fc[k]});
			if (k == 0)
			begin
				ind.lockout_cutoff <= 1'b1;
				repeat (6) @(posedge clk_i);
				chk({4'h0, cmp_act, rails}, 8'h00);
			end
			ind <= '0;
			rst_n <= 1'b1;
			repeat (UP) @(posedge clk_i);
			chk({5'h0, rails}, 8'h07);
			rdchk(ADDR_EVT_EN, 8'h0F);
		end
		final_report();
	end
	// Hang guard, well above the expected run
	initial
	begin
		repeat (60000) @(posedge clk_i);
		err_total++;
		final_report();
	end
endmodule
